/* File: design/tsq_top.sv */
// Serial memory map and operating sequencer of the temperature device
// Summary of operation
// - Results live at 0x010-0x05F, readable serially
// - Instruction 0x03, then address, starts a read
// - Instruction 0x02, address, data bytes writes memory
// - Assignment words at 0x200-0x24F, host writable
// - Writing byte at 0x000 with bit 7 set triggers a measurement
// - Four-byte channel mask at 0x0F4-0x0F7
// - Custom table data at 0x250-0x3CF, 384 bytes
// - Mux settle delay byte at 0x0FF, read-write
// - Wake-up period of 200 ms after power
// - Start-up done: interrupt high, status reads 0x40
// - Enter channel assignment state automatically after start-up
// - Command low bits select the channel to convert, or the mask channels when zero
// - Conversion starts by itself after the command
// - During conversion only status byte is readable
// - Conversion end: interrupt high, start clear, done set
// - Results state gives full memory access
// - End of sleep restarts start-up
// - Low pulse on reset pin restarts start-up
// - First 100 ms phase hides the status byte
// - Until initialised, status reads start flag only
// - Twenty 32-bit assignment words cleared at start-up
`timescale 1ns/10ps
module tsq_top #(
	parameter int WAKE_CYCLES = tsq_pkg::WAKE_CYCLES,
	parameter int PHASE1_CYCLES = tsq_pkg::PHASE1_CYCLES
) (
	// Clocking and power-on reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	// Serial port
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Reset and wake pins
	input wire logic reset_pin_n,
	input wire logic wake_pin,
	// Interrupt pin
	output logic intr,
	// Converter handshake
	output logic conv_start,
	output logic [4:0] conv_channel,
	input wire logic conv_done,
	input wire logic [31:0] conv_result
);
	tsq_pkg::tsq_pins_t pins; // Synchronised pins
	tsq_pkg::tsq_byte_t rx; // Byte from shifter
	tsq_pkg::tsq_seq_t seq; // Sequencer state
	tsq_pkg::tsq_frame_t fr_state; // Frame decoder state
	logic sclk_prev, wake_prev; // Edge detect history
	logic sclk_rise, sclk_fall, wake_rise;
	logic fr_is_read; // Frame is a read
	logic [9:0] frame_addr; // Current byte address
	logic [7:0] mem [0:1023]; // Device memory
	logic [7:0] status_reg; // Command and status byte
	logic [7:0] status_view; // Status as the host sees it
	logic [7:0] rd_value; // Byte offered to the shifter
	logic [24:0] tick; // Start-up timer
	logic [6:0] clear_idx; // Assignment clear pointer
	logic clear_done;
	logic seq_open; // Host has memory access
	logic host_wr; // Host data byte to store
	logic wr_ok, rd_ok; // Address is writable or readable
	logic [19:0] pending; // Channels left in this run
	logic [19:0] next_pending; // Pending set for a new command
	logic [19:0] mask_bits; // Mask bytes as channel bits
	logic [4:0] next_channel; // Lowest pending channel
	logic conv_wait; // Waiting for converter
	logic [9:0] res_base; // Result slot of current channel

	// Pins cross into the clock domain
	// Reset values match the idle pins: serial clock low, deselected, no restart, no wake
	tsq_sync #(.W(5), .INIT(5'h0A)) u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.d({spi_sclk, spi_cs_n, spi_mosi, reset_pin_n, wake_pin}),
		.q(pins)
	);

	// Edge history of serial clock and wake pin
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sclk_prev <= 1'b0;
			wake_prev <= 1'b0;
		end else if (clk_en) begin
			sclk_prev <= pins.sclk;
			wake_prev <= pins.wake;
		end
	end
	assign sclk_rise = pins.sclk & ~sclk_prev;
	assign sclk_fall = ~pins.sclk & sclk_prev;
	assign wake_rise = pins.wake & ~wake_prev;

	// Byte shifter
	tsq_spi_shift u_shift (
		.clock(clock),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.sclk_rise(sclk_rise),
		.sclk_fall(sclk_fall),
		.active(~pins.cs_n),
		.mosi(pins.mosi),
		.miso(spi_miso),
		.miso_oe(spi_miso_oe),
		.tx_byte(rd_value),
		.rx(rx)
	);

	// Frame decoder: instruction, address high, address low, data
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fr_state <= tsq_pkg::FR_INSTR;
			fr_is_read <= 1'b0;
			frame_addr <= 10'h000;
		end else if (clk_en) begin
			if (pins.cs_n) begin
				fr_state <= tsq_pkg::FR_INSTR;
			end else if (rx.valid) begin
				unique case (fr_state)
					tsq_pkg::FR_INSTR: begin
						if (rx.data == tsq_pkg::INSTR_READ) begin
							fr_is_read <= 1'b1;
							fr_state <= tsq_pkg::FR_ADDR_HI;
						end else if (rx.data == tsq_pkg::INSTR_WRITE) begin
							fr_is_read <= 1'b0;
							fr_state <= tsq_pkg::FR_ADDR_HI;
						end else begin
							fr_state <= tsq_pkg::FR_IGNORE;
						end
					end
					tsq_pkg::FR_ADDR_HI: begin
						frame_addr[9:8] <= rx.data[1:0];
						fr_state <= tsq_pkg::FR_ADDR_LO;
					end
					tsq_pkg::FR_ADDR_LO: begin
						frame_addr[7:0] <= rx.data;
						fr_state <= tsq_pkg::FR_DATA;
					end
					tsq_pkg::FR_DATA: begin
						frame_addr <= frame_addr + 10'h001;
					end
					tsq_pkg::FR_IGNORE: begin
						fr_state <= tsq_pkg::FR_IGNORE;
					end
				endcase
			end
		end
	end

	// Access windows of the memory map
	always_comb begin
		seq_open = (seq == tsq_pkg::SQ_ASSIGN) || (seq == tsq_pkg::SQ_RESULTS);
		wr_ok = (frame_addr == tsq_pkg::GLOBAL_CFG)
			|| (frame_addr >= tsq_pkg::MASK_FIRST && frame_addr <= tsq_pkg::MASK_LAST)
			|| (frame_addr == tsq_pkg::MUX_DELAY)
			|| (frame_addr >= tsq_pkg::ASSIGN_FIRST && frame_addr <= tsq_pkg::ASSIGN_LAST)
			|| (frame_addr >= tsq_pkg::TABLE_FIRST && frame_addr <= tsq_pkg::TABLE_LAST);
		rd_ok = wr_ok
			|| (frame_addr >= tsq_pkg::RESULT_FIRST && frame_addr <= tsq_pkg::RESULT_LAST);
	end
	assign host_wr = rx.valid && !pins.cs_n && (fr_state == tsq_pkg::FR_DATA) && !fr_is_read;

	// Status byte as seen by a read
	always_comb begin
		unique case (seq)
			tsq_pkg::SQ_POWER: status_view = tsq_pkg::STATUS_HIDDEN;
			tsq_pkg::SQ_INIT: status_view = tsq_pkg::STATUS_INIT;
			default: status_view = status_reg;
		endcase
	end

	// Read data for the next byte out
	always_comb begin
		rd_value = 8'h00;
		if (fr_state == tsq_pkg::FR_DATA && fr_is_read) begin
			if (frame_addr == tsq_pkg::ADDR_STATUS) begin
				rd_value = status_view;
			end else if (seq_open && rd_ok) begin
				rd_value = mem[frame_addr];
			end
		end
	end

	// Mask bytes: last byte carries channels 1 to 8
	assign mask_bits = {mem[tsq_pkg::MASK_FIRST + 10'h001][3:0],
		mem[tsq_pkg::MASK_FIRST + 10'h002], mem[tsq_pkg::MASK_LAST]};

	// Channel set requested by a command byte
	always_comb begin
		next_pending = 20'h00000;
		if (rx.data[4:0] == 5'h00) begin
			next_pending = mask_bits;
		end else if (rx.data[4:0] <= 5'(tsq_pkg::CHANNELS)) begin
			next_pending[rx.data[4:0] - 5'h01] = 1'b1;
		end
	end

	// Lowest pending channel, numbered from one
	always_comb begin
		next_channel = 5'h00;
		for (int i = tsq_pkg::CHANNELS - 1; i >= 0; i--) begin
			if (pending[i]) begin
				next_channel = 5'(i + 1);
			end
		end
	end
	assign res_base = tsq_pkg::RESULT_FIRST + {3'h0, conv_channel - 5'h01, 2'b00};

	// Memory writes: clear, converter results, host bytes
	always_ff @(posedge clock) begin
		if (clk_en) begin
			if (seq == tsq_pkg::SQ_INIT && !clear_done) begin
				mem[tsq_pkg::ASSIGN_FIRST + {3'h0, clear_idx}] <= 8'h00;
			end else if (seq == tsq_pkg::SQ_CONVERT && conv_wait && conv_done) begin
				mem[res_base] <= conv_result[31:24];
				mem[res_base + 10'h001] <= conv_result[23:16];
				mem[res_base + 10'h002] <= conv_result[15:8];
				mem[res_base + 10'h003] <= conv_result[7:0];
			end else if (host_wr && seq_open && wr_ok) begin
				mem[frame_addr] <= rx.data;
			end
		end
	end

	// Assignment clear pointer, runs during initialisation
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clear_idx <= 7'h00;
		end else if (clk_en) begin
			if (seq != tsq_pkg::SQ_INIT) begin
				clear_idx <= 7'h00;
			end else if (!clear_done) begin
				clear_idx <= clear_idx + 7'h01;
			end
		end
	end
	assign clear_done = (clear_idx == tsq_pkg::ASSIGN_BYTES);

	// Operating sequencer
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			seq <= tsq_pkg::SQ_POWER;
			tick <= 25'h0000000;
			status_reg <= 8'h00;
			pending <= 20'h00000;
			conv_wait <= 1'b0;
			conv_start <= 1'b0;
			conv_channel <= 5'h00;
		end else if (clk_en) begin
			conv_start <= 1'b0;
			if (!pins.reset_n) begin
				seq <= tsq_pkg::SQ_POWER;
				tick <= 25'h0000000;
				conv_wait <= 1'b0;
			end else begin
				unique case (seq)
					tsq_pkg::SQ_POWER: begin
						tick <= tick + 25'h0000001;
						if (tick == 25'(PHASE1_CYCLES - 1)) begin
							seq <= tsq_pkg::SQ_INIT;
						end
					end
					tsq_pkg::SQ_INIT: begin
						tick <= tick + 25'h0000001;
						if (tick >= 25'(WAKE_CYCLES - 1) && clear_done) begin
							seq <= tsq_pkg::SQ_ASSIGN;
							status_reg <= tsq_pkg::STATUS_READY;
						end
					end
					tsq_pkg::SQ_ASSIGN, tsq_pkg::SQ_RESULTS: begin
						if (host_wr && frame_addr == tsq_pkg::ADDR_STATUS) begin
							if (rx.data == tsq_pkg::SLEEP_COMMAND) begin
								seq <= tsq_pkg::SQ_SLEEP;
							end else if (rx.data[tsq_pkg::STATUS_START_BIT]) begin
								status_reg <= rx.data & 8'hBF;
								pending <= next_pending;
								seq <= tsq_pkg::SQ_CONVERT;
							end
						end
					end
					tsq_pkg::SQ_CONVERT: begin
						if (!conv_wait) begin
							if (pending == 20'h00000) begin
								seq <= tsq_pkg::SQ_RESULTS;
								status_reg[tsq_pkg::STATUS_START_BIT] <= 1'b0;
								status_reg[tsq_pkg::STATUS_DONE_BIT] <= 1'b1;
							end else begin
								conv_start <= 1'b1;
								conv_channel <= next_channel;
								conv_wait <= 1'b1;
							end
						end else if (conv_done) begin
							pending[conv_channel - 5'h01] <= 1'b0;
							conv_wait <= 1'b0;
						end
					end
					tsq_pkg::SQ_SLEEP: begin
						tick <= 25'h0000000;
						if (wake_rise) begin
							seq <= tsq_pkg::SQ_POWER;
						end
					end
				endcase
			end
		end
	end

	// Interrupt pin high while idle for the host
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			intr <= 1'b0;
		end else if (clk_en) begin
			intr <= seq_open;
		end
	end

	// Checks on enabled clock edges only
	default clocking cb @(posedge clock iff clk_en);
	endclocking
	default disable iff (!arst_n);

	a_read_decode: assert property (rx.valid && !pins.cs_n && fr_state == tsq_pkg::FR_INSTR
		&& rx.data == 8'h03 |=> fr_state == tsq_pkg::FR_ADDR_HI && fr_is_read)
		else $error("read instruction not decoded");
	a_write_decode: assert property (rx.valid && !pins.cs_n && fr_state == tsq_pkg::FR_INSTR
		&& rx.data == 8'h02 |=> fr_state == tsq_pkg::FR_ADDR_HI && !fr_is_read)
		else $error("write instruction not decoded");
	a_bad_instr: assert property (rx.valid && !pins.cs_n && fr_state == tsq_pkg::FR_INSTR
		&& rx.data != 8'h02 && rx.data != 8'h03 |=> fr_state == tsq_pkg::FR_IGNORE [*2])
		else $error("unknown instruction not ignored");
	a_addr_step: assert property (rx.valid && !pins.cs_n && fr_state == tsq_pkg::FR_DATA
		|=> frame_addr == 10'($past(frame_addr) + 10'h001))
		else $error("address did not advance");
	a_lock_read: assert property (seq == tsq_pkg::SQ_CONVERT && frame_addr != 10'h000
		|-> rd_value == 8'h00)
		else $error("memory readable during conversion");
	a_ready_status: assert property ($past(seq) == tsq_pkg::SQ_INIT
		&& seq == tsq_pkg::SQ_ASSIGN |-> status_reg == 8'h40 ##1 intr)
		else $error("start-up end status wrong");
	a_init_view: assert property (seq == tsq_pkg::SQ_INIT |-> status_view == 8'h80)
		else $error("init status not 0x80");
	a_power_len: assert property ($past(seq) == tsq_pkg::SQ_POWER && seq == tsq_pkg::SQ_INIT
		&& $past(pins.reset_n) |-> $past(tick) == 25'(PHASE1_CYCLES - 1))
		else $error("first phase length wrong");
	a_conv_end: assert property ($past(seq) == tsq_pkg::SQ_CONVERT
		&& seq == tsq_pkg::SQ_RESULTS |-> status_reg[7:6] == 2'b01 ##1 intr)
		else $error("conversion end flags wrong");
	a_pin_reset: assert property (!pins.reset_n |=> seq == tsq_pkg::SQ_POWER)
		else $error("reset pin did not restart");
	a_sleep_wake: assert property (seq == tsq_pkg::SQ_SLEEP && wake_rise && pins.reset_n
		|=> seq == tsq_pkg::SQ_POWER)
		else $error("wake did not restart");
endmodule

/* File: design/tsq_pkg.sv */
// Shared constants, types and memory map of the temperature sequencer
package tsq_pkg;
	// Instruction bytes
	localparam logic [7:0] INSTR_READ = 8'h03;
	localparam logic [7:0] INSTR_WRITE = 8'h02;
	// Byte addresses of the memory map
	localparam logic [9:0] ADDR_STATUS = 10'h000;
	localparam logic [9:0] RESULT_FIRST = 10'h010;
	localparam logic [9:0] RESULT_LAST = 10'h05F;
	localparam logic [9:0] GLOBAL_CFG = 10'h0F0;
	localparam logic [9:0] MASK_FIRST = 10'h0F4;
	localparam logic [9:0] MASK_LAST = 10'h0F7;
	localparam logic [9:0] MUX_DELAY = 10'h0FF;
	localparam logic [9:0] ASSIGN_FIRST = 10'h200;
	localparam logic [9:0] ASSIGN_LAST = 10'h24F;
	localparam logic [9:0] TABLE_FIRST = 10'h250;
	localparam logic [9:0] TABLE_LAST = 10'h3CF;
	// Assignment area size in bytes, cleared at start-up
	localparam logic [6:0] ASSIGN_BYTES = 7'h50;
	// Status byte layout and values
	localparam int STATUS_START_BIT = 7;
	localparam int STATUS_DONE_BIT = 6;
	localparam logic [7:0] STATUS_HIDDEN = 8'h00;
	localparam logic [7:0] STATUS_INIT = 8'h80;
	localparam logic [7:0] STATUS_READY = 8'h40;
	localparam logic [7:0] SLEEP_COMMAND = 8'h7F;
	// Channel count and field width
	localparam int CHANNELS = 20;
	localparam int CHAN_W = 5;
	// Start-up timing
	localparam longint CLOCK_HZ = 100000000;
	localparam longint WAKE_MS = 200;
	localparam longint PHASE1_MS = 100;
	localparam int WAKE_CYCLES = int'(CLOCK_HZ * WAKE_MS / 1000);
	localparam int PHASE1_CYCLES = int'(CLOCK_HZ * PHASE1_MS / 1000);
	// Sequencer states
	typedef enum logic [2:0] {
		SQ_POWER, SQ_INIT, SQ_ASSIGN, SQ_CONVERT, SQ_RESULTS, SQ_SLEEP
	} tsq_seq_t;
	// Frame decoder states
	typedef enum logic [2:0] {
		FR_INSTR, FR_ADDR_HI, FR_ADDR_LO, FR_DATA, FR_IGNORE
	} tsq_frame_t;
	// Pins arriving from outside the clock domain
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic mosi;
		logic reset_n;
		logic wake;
	} tsq_pins_t;
	// One received byte
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} tsq_byte_t;
endpackage

/* File: design/tsq_sync.sv */
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module tsq_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clocking
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta; // First stage, read only by q

	// Two stages in series
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta <= INIT;
			q <= INIT;
		end else if (clk_en) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

/* File: design/tsq_spi_shift.sv */
// Serial byte shifter, mode 0, most significant bit first
`timescale 1ns/10ps
module tsq_spi_shift (
	// Clocking
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	// Serial side, already synchronised
	input wire logic sclk_rise,
	input wire logic sclk_fall,
	input wire logic active,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// Byte side
	input wire logic [7:0] tx_byte,
	output tsq_pkg::tsq_byte_t rx
);
	logic [2:0] bit_cnt; // Bits taken in this byte
	logic [7:0] sh_in; // Receive shift register
	logic [7:0] sh_out; // Transmit shift register

	// Receive on rising edges, flag each complete byte
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt <= 3'h0;
			sh_in <= 8'h00;
			rx <= '0;
		end else if (clk_en) begin
			rx.valid <= 1'b0;
			if (!active) begin
				bit_cnt <= 3'h0;
			end else if (sclk_rise) begin
				sh_in <= {sh_in[6:0], mosi};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					rx.valid <= 1'b1;
					rx.data <= {sh_in[6:0], mosi};
				end
			end
		end
	end

	// Transmit on falling edges, new byte at each boundary
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sh_out <= 8'h00;
			miso <= 1'b0;
			miso_oe <= 1'b0;
		end else if (clk_en) begin
			miso_oe <= active;
			if (!active) begin
				sh_out <= 8'h00;
				miso <= 1'b0;
			end else if (sclk_fall) begin
				if (bit_cnt == 3'h0) begin
					sh_out <= {tx_byte[6:0], 1'b0};
					miso <= tx_byte[7];
				end else begin
					sh_out <= {sh_out[6:0], 1'b0};
					miso <= sh_out[7];
				end
			end
		end
	end
endmodule

/* File: testbench/tsq_host.sv */
// Host controller model acting as serial bus master, mode 0
`timescale 1ns/10ps
module tsq_host (
	// Clocking
	input wire logic clock,
	// Serial port
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe
);
	// Idle bus: clock low, deselected
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// One byte, MSB first; bit periods alternate 12 and 13 cycles for a 125 ns mean period
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--) begin
			spi_mosi <= tx[b];
			repeat (6) @(posedge clock);
			spi_sclk <= 1'b1;
			// A released data line must not pass as a valid bit
			rx[b] = spi_miso_oe ? spi_miso : 1'bx;
			repeat (6 + b % 2) @(posedge clock);
			spi_sclk <= 1'b0;
		end
	endtask

	// Whole frame: instruction, address high then low, then n data bytes
	task automatic frame(input logic [7:0] ins, input logic [9:0] a, input int n,
		input logic [31:0] wd, output logic [31:0] rd);
		logic [7:0] r;
		rd = '0;
		@(posedge clock);
		spi_cs_n <= 1'b0;
		shift(ins, r);
		shift({6'h00, a[9:8]}, r);
		shift(a[7:0], r);
		// Data bytes right aligned, first byte most significant
		for (int i = 0; i < n; i++) begin
			shift(wd[8 * (n - 1 - i) +: 8], r);
			rd = {rd[23:0], r};
		end
		repeat (3) @(posedge clock);
		spi_cs_n <= 1'b1;
		// Undriven data line shows a changed level between frames
		spi_mosi <= ~spi_mosi;
		repeat (4) @(posedge clock);
	endtask
endmodule

/* File: testbench/tsq_top_tb.sv */
// Self-checking testbench of the temperature sequencer
`timescale 1ns/10ps
module tsq_top_tb;
	logic clock;
	logic arst_n;
	logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	logic reset_pin_n;
	logic wake_pin;
	logic clk_en; // Clock enable, frozen in one scenario
	logic intr, conv_start;
	logic conv_done = 1'b0; // Converter done pulse
	logic [4:0] conv_channel;
	logic [31:0] conv_result = 32'h0; // Converter result word
	int mismatches = 0;
	int comparisons = 0;
	int conv_wait = 0; // Converter busy countdown
	logic [4:0] conv_seen[$]; // Channels the converter was asked for

	// Shortened start-up counts
	tsq_top #(.WAKE_CYCLES(3000), .PHASE1_CYCLES(1000)) i_dut (
		.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
		.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
		.reset_pin_n(reset_pin_n), .wake_pin(wake_pin), .intr(intr),
		.conv_start(conv_start), .conv_channel(conv_channel),
		.conv_done(conv_done), .conv_result(conv_result)
	);
	tsq_host i_host (
		.clock(clock), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
	);

	// Clock, 10 ns period
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Slow converter: answers 2000 cycles after each start with a tagged result
	always @(posedge clock) begin
		conv_done <= 1'b0;
		if (conv_start === 1'b1) begin
			conv_wait <= 2000;
			conv_seen.push_back(conv_channel);
			conv_result <= {8'h5A, 19'h00000, conv_channel};
		end else if (conv_wait == 1) begin
			conv_done <= 1'b1;
			conv_wait <= 0;
		end else if (conv_wait > 1) begin
			conv_wait <= conv_wait - 1;
		end
	end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
		end
	endtask

	// Counts and verdict, then stop
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Bounded wait for the interrupt level; running out ends the run
	task automatic wait_intr(input logic lvl, input int lim);
		int k = 0;
		while (intr !== lvl && k < lim) begin
			@(posedge clock);
			k++;
		end
		// Only a level still wrong after the bound counts as a timeout
		if (intr !== lvl) begin
			check({31'h0, intr}, {31'h0, lvl});
			conclude();
		end
	endtask

	// Bus helpers
	task automatic rd(input logic [9:0] a, input int n, input logic [31:0] exp);
		logic [31:0] r;
		i_host.frame(tsq_pkg::INSTR_READ, a, n, 32'h0, r);
		check(r, exp);
	endtask
	task automatic wr(input logic [9:0] a, input int n, input logic [31:0] d);
		logic [31:0] r;
		i_host.frame(tsq_pkg::INSTR_WRITE, a, n, d, r);
	endtask

	// Start-up phases as seen through the status byte
	task automatic t_startup();
		rd(tsq_pkg::ADDR_STATUS, 1, tsq_pkg::STATUS_HIDDEN);
		repeat (700) @(posedge clock);
		rd(tsq_pkg::ADDR_STATUS, 1, tsq_pkg::STATUS_INIT);
		check({31'h0, intr}, 32'h0);
		wait_intr(1'b1, 3000);
		rd(tsq_pkg::ADDR_STATUS, 1, tsq_pkg::STATUS_READY);
		rd(10'h24C, 4, 32'h0);
	endtask

	// Register and area access, address increment, unknown instruction
	task automatic t_memory();
		logic [31:0] r;
		wr(tsq_pkg::MUX_DELAY, 1, 32'h3C);
		rd(tsq_pkg::MUX_DELAY, 1, 32'h3C);
		wr(tsq_pkg::GLOBAL_CFG, 1, 32'hA7);
		rd(tsq_pkg::GLOBAL_CFG, 1, 32'hA7);
		wr(tsq_pkg::ASSIGN_FIRST, 4, 32'h1234_5678);
		rd(tsq_pkg::ASSIGN_FIRST, 4, 32'h1234_5678);
		wr(tsq_pkg::ASSIGN_LAST, 2, 32'h9ABC);
		rd(tsq_pkg::ASSIGN_LAST, 2, 32'h9ABC);
		wr(tsq_pkg::TABLE_LAST, 1, 32'h6E);
		rd(tsq_pkg::TABLE_LAST, 1, 32'h6E);
		i_host.frame(8'h05, tsq_pkg::MUX_DELAY, 1, 32'h00, r);
		rd(tsq_pkg::MUX_DELAY, 1, 32'h3C);
	endtask

	// Masked run over channels 1 and 3, lockout while converting
	task automatic t_mask_run();
		wr(tsq_pkg::MASK_FIRST, 4, 32'h0000_0005);
		wr(tsq_pkg::ADDR_STATUS, 1, 32'h80);
		rd(tsq_pkg::ADDR_STATUS, 1, 32'h80);
		rd(tsq_pkg::GLOBAL_CFG, 1, 32'h00);
		wait_intr(1'b1, 8000);
		rd(tsq_pkg::ADDR_STATUS, 1, tsq_pkg::STATUS_READY);
		check({27'h0, conv_seen.pop_front()}, 32'h1);
		check({27'h0, conv_seen.pop_front()}, 32'h3);
		wr(tsq_pkg::RESULT_FIRST, 1, 32'hFF);
		rd(tsq_pkg::RESULT_FIRST, 4, 32'h5A00_0001);
		rd(10'h018, 4, 32'h5A00_0003);
	endtask

	// Single channel command, converter sees that channel only
	task automatic t_single();
		wr(tsq_pkg::ADDR_STATUS, 1, 32'h94);
		wait_intr(1'b1, 5000);
		rd(tsq_pkg::ADDR_STATUS, 1, 32'h54);
		check({27'h0, conv_seen.pop_front()}, 32'h14);
		check(conv_seen.size(), 32'h0);
		rd(tsq_pkg::RESULT_LAST - 10'h3, 4, 32'h5A00_0014);
	endtask

	// Reset pin pulse restarts start-up and clears assignments
	task automatic t_reset_pin();
		// A pulse while the clock enable is low must leave everything frozen
		clk_en <= 1'b0;
		reset_pin_n <= 1'b0;
		repeat (10) @(posedge clock);
		reset_pin_n <= 1'b1;
		repeat (4) @(posedge clock);
		clk_en <= 1'b1;
		repeat (10) @(posedge clock);
		check({31'h0, intr}, 32'h1);
		reset_pin_n <= 1'b0;
		repeat (10) @(posedge clock);
		check({31'h0, intr}, 32'h0);
		reset_pin_n <= 1'b1;
		wait_intr(1'b1, 5000);
		rd(tsq_pkg::ASSIGN_FIRST, 4, 32'h0);
	endtask

	// Sleep command, then wake edge restarts start-up
	task automatic t_sleep();
		wr(tsq_pkg::ASSIGN_FIRST, 1, 32'h11);
		wr(tsq_pkg::ADDR_STATUS, 1, {24'h0, tsq_pkg::SLEEP_COMMAND});
		repeat (50) @(posedge clock);
		check({31'h0, intr}, 32'h0);
		wake_pin <= 1'b1;
		wait_intr(1'b1, 5000);
		wake_pin <= 1'b0;
		rd(tsq_pkg::ASSIGN_FIRST, 1, 32'h0);
	endtask

	// Main sequence
	initial begin
		arst_n = 1'b0;
		reset_pin_n = 1'b1;
		wake_pin = 1'b0;
		clk_en = 1'b1;
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		t_startup();
		t_memory();
		t_mask_run();
		t_single();
		t_reset_pin();
		t_sleep();
		conclude();
	end
endmodule
